/* logic/tmr_core.sv */
// Purpose: 16-bit timer with prescaler, four match and two capture channels
// Assumes: Avalon-MM slave, one wait state on every access
// Notes: Capture and count inputs sampled synchronously, edges seen in the cycle the new level arrives
//
// How it works
// [RL1] Reading interrupt_flags shows the pending sources and writing it clears the chosen ones.
// [RL2] In timer mode the main count steps once per prescale_limit plus one clocks while enabled.
// [RL3] When the prescale count equals the limit the next edge steps the main count and zeroes the prescale count.
// [RL4] Software can read and overwrite the prescale count over the bus.
// [RL5] Timer control holds an enable bit and a bit that holds both counters in reset.
// [RL6] Each match channel can reset the count, stop both counters and raise a flag on equality.
// [RL7] Capture control picks the edges of each capture input and whether a capture raises a flag.
// [RL8] A chosen capture edge copies the main count into its read-only capture register.
// [RL9] Match output control holds and drives the three match output pins.
// [RL10] Count source control picks timer mode or counting edges of a chosen input.
// [RL11] PWM enable control moves individual match pins into PWM operation.
// [RL12] Every implemented register bit is zero after reset, reserved bits read zero except bit 3 of match output control, which keeps what is written.
// [RL13] Flags 0 to 3 are the match channels, 4 and 5 the captures, one clears, zero keeps.
// [RL14] On a match each pin toggles, goes low, goes high or keeps its level as set.
// [RL15] Stop on match clears the enable bit on the clock after the count reaches the match value; in edge modes, on the next counted edge.
// [RL16] Software running PWM keeps reset and stop off on all channels but the period channel.
// [RL17] Reserved offsets read zero and ignore writes.

`timescale 1ns/1ps

module tmr_core (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Register bus
   input wire tmr_pkg::tmr_req_type bus_req,
   output tmr_pkg::tmr_rsp_type bus_rsp,
   // Capture pins
   input wire logic capture_input_0,
   input wire logic capture_input_1,
   // Match pins
   output logic [2:0] match_outputs
);
   import tmr_pkg::*;

   logic [TMR_FLAG_W-1:0] flags_reg, flags_next;
   logic [1:0] ctrl_reg, ctrl_next;
   logic [15:0] count_reg, count_next;
   logic [15:0] plim_reg, plim_next;
   logic [15:0] pcnt_reg, pcnt_next;
   logic [TMR_MACT_W-1:0] mact_reg, mact_next;
   logic [15:0] mval_reg [4];
   logic [15:0] mval_next [4];
   logic [TMR_CEDGE_W-1:0] cedge_reg, cedge_next;
   logic [15:0] cval_reg [2];
   logic [15:0] cval_next [2];
   logic [TMR_MOUT_W-1:0] mout_reg, mout_next;
   logic [TMR_CSRC_W-1:0] csrc_reg, csrc_next;
   logic [TMR_PWM_W-1:0] pwm_reg, pwm_next;
   logic [2:0] pins_reg, pins_next;
   tmr_rsp_type rsp_reg, rsp_next;
   logic busy_reg, busy_next;

   logic [1:0] cap_rise, cap_fall;
   logic [1:0] cap_lvl;
   logic [3:0] hit;
   logic [1:0] cap_hit;
   // Match arrival and PWM levels
   logic [3:0] evt;
   logic [2:0] pwm_lvl;
   logic tick;
   logic step;
   logic cnt_edge;
   logic wr_take;
   logic rd_take;
   logic [31:0] rd_data;

   assign cap_lvl = {capture_input_1, capture_input_0};

   // One edge detector per capture pin
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_edge
         tmr_edge u_edge (
            .clk(clk),
            .rst(rst),
            .level(cap_lvl[gi]),
            .rise(cap_rise[gi]),
            .fall(cap_fall[gi])
         );
      end
   endgenerate

   // Access is taken on the cycle waitrequest is low
   assign wr_take = bus_req.write & busy_reg;
   assign rd_take = bus_req.read & busy_reg;

   // Counting source: clock in timer mode, selected input edges otherwise
   always_comb begin
      logic [1:0] sel;
      sel = csrc_reg[3:2];
      cnt_edge = 1'b0;
      unique case (csrc_reg[1:0]) // RL10
         TMR_MODE_TIMER: cnt_edge = 1'b1; // RL2
         TMR_MODE_RISE: cnt_edge = cap_rise[sel[0]];
         TMR_MODE_FALL: cnt_edge = cap_fall[sel[0]];
         TMR_MODE_BOTH: cnt_edge = cap_rise[sel[0]] | cap_fall[sel[0]];
      endcase
   end

   // Prescale wrap produces the count step
   assign tick = ctrl_reg[TMR_CTRL_EN] & ~ctrl_reg[TMR_CTRL_RST] & cnt_edge;
   assign step = tick & (pcnt_reg == plim_reg); // RL3

   // Match equality, evaluated against the present count
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         hit[i] = (count_reg == mval_reg[i]);
      end
      for (int i = 0; i < 2; i++) begin
         cap_hit[i] = (cedge_reg[3*i] & cap_rise[i]) | (cedge_reg[3*i+1] & cap_fall[i]); // RL7
      end
   end

   // Match arrival: the count has just reached a match value while the
   // prescaler sits at zero, so each value fires once, not once per tick.
   // Limitation: a count written onto a match value mid-prescale is missed
   // until the count comes round to it again.
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         evt[i] = hit[i] & tick & (pcnt_reg == TMR_RST_16); // RL6
      end
   end

   // PWM level per pin: high once the count has reached its match value
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         pwm_lvl[i] = (count_reg >= mval_reg[i]); // RL11
      end
   end

   // Counters, match actions and flags
   always_comb begin
      logic m_reset;
      logic m_stop;
      logic [15:0] wv;
      m_reset = 1'b0;
      m_stop = 1'b0;
      wv = bus_req.writedata[15:0];
      flags_next = flags_reg;
      ctrl_next = ctrl_reg;
      count_next = count_reg;
      pcnt_next = pcnt_reg;
      pins_next = pins_reg;
      cval_next = cval_reg;
      // Flag and stop on arrival; reset on the step leaving the value,
      // which gives the match value a full count period before the wrap
      for (int i = 0; i < 4; i++) begin
         if (evt[i]) begin
            if (mact_reg[3*i]) begin
               flags_next[i] = 1'b1; // RL6
            end
            m_stop = m_stop | mact_reg[3*i+2]; // RL15
         end
         if (hit[i] && step) begin
            m_reset = m_reset | mact_reg[3*i+1]; // RL6
         end
      end
      // Pin actions on match; PWM pins follow count against match level
      for (int i = 0; i < 3; i++) begin
         if (pwm_reg[i]) begin
            pins_next[i] = pwm_lvl[i]; // RL11
         end else if (evt[i]) begin
            unique case (mout_reg[TMR_MOUT_ACT+2*i +: 2]) // RL14
               TMR_ACT_NONE: pins_next[i] = pins_reg[i];
               TMR_ACT_LOW: pins_next[i] = 1'b0;
               TMR_ACT_HIGH: pins_next[i] = 1'b1;
               TMR_ACT_TOGGLE: pins_next[i] = ~pins_reg[i];
            endcase
         end
      end
      // Prescaler and main count
      if (ctrl_reg[TMR_CTRL_RST]) begin
         count_next = TMR_RST_16; // RL5
         pcnt_next = TMR_RST_16;
      end else if (m_stop) begin
         // Stop halts both counters on the clock that clears the enable
         // and outranks a reset, so the count rests on the match value
         count_next = count_reg; // RL15
         pcnt_next = pcnt_reg;
      end else if (step) begin
         pcnt_next = TMR_RST_16; // RL3
         count_next = m_reset ? TMR_RST_16 : 16'(count_reg + 16'h0001); // RL6
      end else if (tick) begin
         pcnt_next = 16'(pcnt_reg + 16'h0001); // RL2
      end
      // Enable drops on the first tick after the count reached the match value: the next clock in timer mode, the next counted edge in edge modes
      if (m_stop) begin
         ctrl_next[TMR_CTRL_EN] = 1'b0; // RL15
      end
      // Captures
      for (int i = 0; i < 2; i++) begin
         if (cap_hit[i]) begin
            cval_next[i] = count_reg; // RL8
         end
      end
      // Bus writes: clear first so a same-cycle event still sets
      if (wr_take) begin
         unique case (bus_req.address)
            TMR_OFS_FLAGS: flags_next = flags_reg & ~bus_req.writedata[TMR_FLAG_W-1:0]; // RL13
            TMR_OFS_CTRL: ctrl_next = bus_req.writedata[1:0]; // RL5
            TMR_OFS_COUNT: count_next = wv;
            TMR_OFS_PCNT: pcnt_next = wv; // RL4
            TMR_OFS_MOUT: pins_next = bus_req.writedata[2:0]; // RL9
            default: ;
         endcase
         // A match event in the clearing cycle sets its flag again
         if (bus_req.address == TMR_OFS_FLAGS) begin
            for (int i = 0; i < 4; i++) begin
               if (evt[i] && mact_reg[3*i]) begin
                  flags_next[i] = 1'b1; // RL1
               end
            end
         end
      end
      // Capture flags set after any clear
      for (int i = 0; i < 2; i++) begin
         if (cap_hit[i] && cedge_reg[3*i+2]) begin
            flags_next[TMR_FLAG_CAP+i] = 1'b1; // RL7
         end
      end
   end

   // Plain configuration registers
   always_comb begin
      plim_next = plim_reg;
      mact_next = mact_reg;
      mval_next = mval_reg;
      cedge_next = cedge_reg;
      mout_next = mout_reg;
      csrc_next = csrc_reg;
      pwm_next = pwm_reg;
      if (wr_take) begin
         unique case (bus_req.address)
            TMR_OFS_PLIM: plim_next = bus_req.writedata[15:0];
            TMR_OFS_MACT: mact_next = bus_req.writedata[TMR_MACT_W-1:0]; // RL6
            TMR_OFS_CEDGE: cedge_next = bus_req.writedata[TMR_CEDGE_W-1:0]; // RL7
            TMR_OFS_MOUT: mout_next = bus_req.writedata[TMR_MOUT_W-1:0]; // RL9
            TMR_OFS_CSRC: csrc_next = bus_req.writedata[TMR_CSRC_W-1:0]; // RL10
            TMR_OFS_PWM: pwm_next = bus_req.writedata[TMR_PWM_W-1:0]; // RL11
            default: ; // RL17
         endcase
         for (int i = 0; i < 4; i++) begin
            if (bus_req.address == 7'(TMR_OFS_MV0 + 7'(4*i))) begin
               mval_next[i] = bus_req.writedata[15:0];
            end
         end
      end
      // Pin state bits mirror the driven pins
      mout_next[2:0] = pins_next; // RL9
   end

   // Read mux, reserved and unmapped offsets read zero
   always_comb begin
      rd_data = TMR_RST_32;
      unique case (bus_req.address)
         TMR_OFS_FLAGS: rd_data = 32'(flags_reg); // RL1
         TMR_OFS_CTRL: rd_data = 32'(ctrl_reg);
         TMR_OFS_COUNT: rd_data = 32'(count_reg);
         TMR_OFS_PLIM: rd_data = 32'(plim_reg);
         TMR_OFS_PCNT: rd_data = 32'(pcnt_reg); // RL4
         TMR_OFS_MACT: rd_data = 32'(mact_reg);
         TMR_OFS_CEDGE: rd_data = 32'(cedge_reg);
         TMR_OFS_CV0: rd_data = 32'(cval_reg[0]); // RL8
         TMR_OFS_CV1: rd_data = 32'(cval_reg[1]);
         TMR_OFS_MOUT: rd_data = 32'(mout_reg);
         TMR_OFS_CSRC: rd_data = 32'(csrc_reg);
         TMR_OFS_PWM: rd_data = 32'(pwm_reg);
         default: rd_data = TMR_RST_32; // RL17
      endcase
      for (int i = 0; i < 4; i++) begin
         if (bus_req.address == 7'(TMR_OFS_MV0 + 7'(4*i))) begin
            rd_data = 32'(mval_reg[i]);
         end
      end
   end

   // Bus handshake: one wait cycle, then answer; registered waitrequest
   always_comb begin
      busy_next = 1'b0;
      rsp_next.waitrequest = 1'b1;
      rsp_next.readdata = rsp_reg.readdata;
      if ((bus_req.read || bus_req.write) && !busy_reg) begin
         busy_next = 1'b1;
         rsp_next.waitrequest = 1'b0;
         rsp_next.readdata = rd_data;
      end
      if (rd_take) begin
         rsp_next.readdata = rsp_reg.readdata;
      end
   end

   // All state registers, zero at reset except waitrequest, which resets high
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         flags_reg <= '0; // RL12
         ctrl_reg <= '0;
         count_reg <= TMR_RST_16;
         plim_reg <= TMR_RST_16;
         pcnt_reg <= TMR_RST_16;
         mact_reg <= '0;
         for (int i = 0; i < 4; i++) begin
            mval_reg[i] <= TMR_RST_16;
         end
         cedge_reg <= '0;
         cval_reg[0] <= TMR_RST_16;
         cval_reg[1] <= TMR_RST_16;
         mout_reg <= '0;
         csrc_reg <= '0;
         pwm_reg <= '0;
         pins_reg <= 3'h0;
         rsp_reg <= '{readdata: 32'h0000_0000, waitrequest: 1'b1};
         busy_reg <= 1'b0;
      end else begin
         flags_reg <= flags_next;
         ctrl_reg <= ctrl_next;
         count_reg <= count_next;
         plim_reg <= plim_next;
         pcnt_reg <= pcnt_next;
         mact_reg <= mact_next;
         mval_reg <= mval_next;
         cedge_reg <= cedge_next;
         cval_reg <= cval_next;
         mout_reg <= mout_next;
         csrc_reg <= csrc_next;
         pwm_reg <= pwm_next;
         pins_reg <= pins_next;
         rsp_reg <= rsp_next;
         busy_reg <= busy_next;
      end
   end

   // Outputs straight from flip-flops
   assign bus_rsp = rsp_reg;
   assign match_outputs = pins_reg; // RL9
endmodule

/* logic/tmr_edge.sv */
// Purpose: Edge detector for one synchronous capture or count input
// Assumes: Input already synchronous to clk
// Notes: No added latency, rise and fall follow level in the same cycle; pulses are one cycle wide

`timescale 1ns/1ps

module tmr_edge (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Sampled level and detected edges
   input wire logic level,
   output logic rise,
   output logic fall
);
   logic last_reg;
   logic last_next;

   // Previous level
   always_comb begin
      last_next = level;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         last_reg <= 1'b0;
      end else begin
         last_reg <= last_next;
      end
   end

   assign rise = level & ~last_reg;
   assign fall = ~level & last_reg;
endmodule

/* logic/tmr_pkg.sv */
// Purpose: Shared constants and types for the 16-bit match/capture timer
// Assumes: 32-bit Avalon-MM register port, byte addresses, word aligned
// Notes: Field layouts of control registers are chosen here

package tmr_pkg;
   // Register byte offsets
   localparam logic [6:0] TMR_OFS_FLAGS = 7'h00;
   localparam logic [6:0] TMR_OFS_CTRL = 7'h04;
   localparam logic [6:0] TMR_OFS_COUNT = 7'h08;
   localparam logic [6:0] TMR_OFS_PLIM = 7'h0C;
   localparam logic [6:0] TMR_OFS_PCNT = 7'h10;
   localparam logic [6:0] TMR_OFS_MACT = 7'h14;
   localparam logic [6:0] TMR_OFS_MV0 = 7'h18;
   localparam logic [6:0] TMR_OFS_MV1 = 7'h1C;
   localparam logic [6:0] TMR_OFS_MV2 = 7'h20;
   localparam logic [6:0] TMR_OFS_MV3 = 7'h24;
   localparam logic [6:0] TMR_OFS_CEDGE = 7'h28;
   localparam logic [6:0] TMR_OFS_CV0 = 7'h2C;
   localparam logic [6:0] TMR_OFS_CV1 = 7'h30;
   localparam logic [6:0] TMR_OFS_MOUT = 7'h3C;
   localparam logic [6:0] TMR_OFS_CSRC = 7'h70;
   localparam logic [6:0] TMR_OFS_PWM = 7'h74;

   // Timer control fields
   localparam int TMR_CTRL_EN = 0;
   localparam int TMR_CTRL_RST = 1;
   // Match action fields: channel n uses bits 3n (irq), 3n+1 (reset), 3n+2 (stop)
   localparam int TMR_MACT_W = 12;
   // Capture control: channel n bits 3n rise, 3n+1 fall, 3n+2 irq
   localparam int TMR_CEDGE_W = 6;
   // Match output control: bits 2:0 pin state, 2n+5:2n+4 action for pin n
   localparam int TMR_MOUT_W = 10;
   localparam int TMR_MOUT_ACT = 4;
   // Count source: bits 1:0 mode, bits 3:2 input select
   localparam int TMR_CSRC_W = 4;
   localparam int TMR_PWM_W = 3;
   localparam int TMR_FLAG_W = 6;
   localparam int TMR_FLAG_CAP = 4;

   localparam logic [15:0] TMR_RST_16 = 16'h0000;
   localparam logic [31:0] TMR_RST_32 = 32'h0000_0000;

   // Match output actions
   localparam logic [1:0] TMR_ACT_NONE = 2'h0;
   localparam logic [1:0] TMR_ACT_LOW = 2'h1;
   localparam logic [1:0] TMR_ACT_HIGH = 2'h2;
   localparam logic [1:0] TMR_ACT_TOGGLE = 2'h3;

   // Count modes
   localparam logic [1:0] TMR_MODE_TIMER = 2'h0;
   localparam logic [1:0] TMR_MODE_RISE = 2'h1;
   localparam logic [1:0] TMR_MODE_FALL = 2'h2;
   localparam logic [1:0] TMR_MODE_BOTH = 2'h3;

   // Bus request carrier
   typedef struct packed {
      logic [6:0] address;
      logic read;
      logic write;
      logic [31:0] writedata;
   } tmr_req_type;

   // Bus answer carrier
   typedef struct packed {
      logic [31:0] readdata;
      logic waitrequest;
   } tmr_rsp_type;
endpackage

/* test/tmr_core_asserts.sv */
// Purpose: Port-level checker for the match/capture timer
// Assumes: One clock domain, asynchronous active-high reset
// Notes: Bound onto the core at the foot of this file

`timescale 1ns/1ps

module tmr_core_asserts (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Register bus
   input wire tmr_pkg::tmr_req_type bus_req,
   input wire tmr_pkg::tmr_rsp_type bus_rsp,
   // Pins
   input wire logic capture_input_0,
   input wire logic capture_input_1,
   input wire logic [2:0] match_outputs
);
   import tmr_pkg::*;
   logic req_any;
   logic rd_done;
   logic wr_pins;
   logic [2:0] pins_last;
   // Completion cycles of bus accesses
   assign req_any = bus_req.read || bus_req.write;
   assign rd_done = bus_req.read && !bus_rsp.waitrequest;
   assign wr_pins = bus_req.write && !bus_rsp.waitrequest && bus_req.address == TMR_OFS_MOUT;
   // Last pin state written, so the pin check needs no local variable
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pins_last <= 3'h0;
      end else if (wr_pins) begin
         pins_last <= bus_req.writedata[2:0];
      end
   end
   function automatic logic rsv(input logic [6:0] a);
      return a == 7'h34 || a == 7'h38 || (a >= 7'h40 && a <= 7'h6C) || a > TMR_OFS_PWM;
   endfunction
   function automatic logic half(input logic [6:0] a);
      return (a >= TMR_OFS_COUNT && a <= TMR_OFS_MV3) || a == TMR_OFS_CV0 || a == TMR_OFS_CV1;
   endfunction
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence acc_start;
      $rose(req_any);
   endsequence
   sequence pin_follow;
      ##[1:2] match_outputs == pins_last;
   endsequence
   answer_one_a: assert property (acc_start |=> !bus_rsp.waitrequest)
      else $error("no answer one cycle after request");
   wait_pulse_a: assert property (!bus_rsp.waitrequest |=> bus_rsp.waitrequest)
      else $error("waitrequest low for more than one cycle");
   idle_answer_a: assert property (!bus_rsp.waitrequest |-> $past(req_any))
      else $error("answer without request");
   reserved_zero_a: assert property (rd_done && rsv(bus_req.address) |-> bus_rsp.readdata == 32'h0000_0000)
      else $error("reserved offset read not zero");
   upper_zero_a: assert property (rd_done && half(bus_req.address) |-> bus_rsp.readdata[31:16] == 16'h0000)
      else $error("upper half of 16-bit register not zero");
   flags_width_a: assert property (rd_done && bus_req.address == TMR_OFS_FLAGS |-> bus_rsp.readdata[31:6] == 26'h0)
      else $error("flag register reserved bits set");
   reset_state_a: assert property ($fell(rst) |-> bus_rsp.waitrequest && match_outputs == 3'h0)
      else $error("outputs not idle after reset");
   pin_write_a: assert property (wr_pins |-> pin_follow)
      else $error("match pins do not follow written state");
endmodule

bind tmr_core tmr_core_asserts i_chk (.clk(clk), .rst(rst), .bus_req(bus_req), .bus_rsp(bus_rsp),
   .capture_input_0(capture_input_0), .capture_input_1(capture_input_1), .match_outputs(match_outputs));

/* test/tmr_core_tb_top.sv */
// Purpose: Self-checking bench for the match/capture timer
// Assumes: Bus answers after one wait cycle
// Notes: Free-running count checks allow one step of slack

`timescale 1ns/1ps

module tmr_core_tb_top;
   import tmr_pkg::*;
   typedef struct packed {logic [6:0] a; logic [31:0] d; logic [31:0] e;} tmr_row_type;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [1:0] want = 2'h0;
   tmr_req_type req = '0;
   tmr_rsp_type rsp;
   logic cap0;
   logic cap1;
   logic [2:0] pins;
   logic [31:0] rd;
   int error_cnt = 0;
   int n_checks = 0;
   tmr_row_type rows [13] = '{'{TMR_OFS_PLIM, 32'hFFFF_1234, 32'h1234}, '{TMR_OFS_PCNT, 32'hABCD, 32'hABCD},
      '{TMR_OFS_MACT, 32'hFFF, 32'hFFF}, '{TMR_OFS_MV3, 32'hFFFF, 32'hFFFF}, '{TMR_OFS_CEDGE, 32'h3F, 32'h3F},
      '{TMR_OFS_CV0, 32'hAAAA, 32'h0}, '{TMR_OFS_CV1, 32'h5555, 32'h0}, '{7'h34, 32'hFFFF_FFFF, 32'h0},
      '{7'h40, 32'h1, 32'h0}, '{7'h6C, 32'h1, 32'h0}, '{TMR_OFS_CSRC, 32'hF, 32'hF},
      '{TMR_OFS_PWM, 32'h7, 32'h7}, '{TMR_OFS_FLAGS, 32'h3F, 32'h0}};
   // Half period of the 125 MHz clock
   always #4 clk = ~clk;
   tmr_pins i_pins (.clk(clk), .want(want), .capture_input_0(cap0), .capture_input_1(cap1));
   tmr_core i_dut (.clk(clk), .rst(rst), .bus_req(req), .bus_rsp(rsp), .capture_input_0(cap0),
      .capture_input_1(cap1), .match_outputs(pins));
   task end_of_test;
      $display("Checks %0d, errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // One Avalon access; request held until waitrequest is sampled low
   task bus(input logic w, input logic [6:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      req.address <= a;
      req.read <= !w;
      req.write <= w;
      req.writedata <= d;
      do begin
         @(posedge clk);
         n++;
      end while (rsp.waitrequest !== 1'b0 && n < 50);
      rd = rsp.readdata;
      req.read <= 1'b0;
      req.write <= 1'b0;
      if (n >= 50) begin
         error_cnt++;
         end_of_test;
      end
   endtask
   task wr(input logic [6:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task rdc(input string nm, input logic [6:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(nm, e, rd);
   endtask
   // Pin change, then time for the edge to be seen
   task pin(input logic [1:0] v);
      want <= v;
      repeat (4) @(posedge clk);
   endtask
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      // Reset values of every word up to the last register
      for (int i = 0; i < 30; i++) begin
         rdc("reset value", 7'(i * 4), 32'h0);
      end
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         rdc("row readback", rows[i].a, rows[i].e);
      end
      wr(TMR_OFS_CSRC, 32'h0);
      wr(TMR_OFS_PWM, 32'h0);
      wr(TMR_OFS_CEDGE, 32'h0);
      wr(TMR_OFS_PCNT, 32'h0);
      // Stop and flag on match, limit 2, match 6
      wr(TMR_OFS_PLIM, 32'h2);
      wr(TMR_OFS_MV0, 32'h6);
      wr(TMR_OFS_MACT, 32'h5);
      wr(TMR_OFS_CTRL, 32'h1);
      repeat (40) @(posedge clk);
      rdc("stop count", TMR_OFS_COUNT, 32'h6);
      rdc("stop enable", TMR_OFS_CTRL, 32'h0);
      rdc("match flag", TMR_OFS_FLAGS, 32'h1);
      wr(TMR_OFS_FLAGS, 32'h3E);
      rdc("zero keeps flag", TMR_OFS_FLAGS, 32'h1);
      wr(TMR_OFS_FLAGS, 32'h1);
      rdc("one clears flag", TMR_OFS_FLAGS, 32'h0);
      // Counter reset, then free run with limit 3 for about 102 clocks
      wr(TMR_OFS_CTRL, 32'h2);
      rdc("held count", TMR_OFS_COUNT, 32'h0);
      rdc("held prescale", TMR_OFS_PCNT, 32'h0);
      wr(TMR_OFS_MACT, 32'h0);
      wr(TMR_OFS_PLIM, 32'h3);
      wr(TMR_OFS_CTRL, 32'h1);
      repeat (100) @(posedge clk);
      wr(TMR_OFS_CTRL, 32'h0);
      bus(1'b0, TMR_OFS_COUNT, 32'h0);
      n_checks++;
      if (rd !== 32'd25 && rd !== 32'd26) begin
         error_cnt++;
         $display("[FAIL] run count expected 25 or 26 seen %h", rd);
      end
      bus(1'b0, TMR_OFS_PCNT, 32'h0);
      chk("prescale below limit", 32'h0, {30'h0, rd[31:2]});
      // Reset on match of channel 1 keeps the count within 0 to 9
      wr(TMR_OFS_PLIM, 32'h0);
      wr(TMR_OFS_MV1, 32'h9);
      wr(TMR_OFS_MACT, 32'h18);
      wr(TMR_OFS_CTRL, 32'h2);
      wr(TMR_OFS_CTRL, 32'h1);
      repeat (50) @(posedge clk);
      wr(TMR_OFS_CTRL, 32'h0);
      bus(1'b0, TMR_OFS_COUNT, 32'h0);
      chk("wrapped count", 32'h1, 32'(rd <= 32'd9));
      rdc("period flag", TMR_OFS_FLAGS, 32'h2);
      wr(TMR_OFS_FLAGS, 32'h2);
      // Capture 0 on rise with flag, capture 1 on fall only
      wr(TMR_OFS_MACT, 32'h0);
      wr(TMR_OFS_CEDGE, 32'h15);
      wr(TMR_OFS_COUNT, 32'h100);
      pin(2'h1);
      wr(TMR_OFS_COUNT, 32'h200);
      pin(2'h0);
      pin(2'h2);
      wr(TMR_OFS_COUNT, 32'h300);
      pin(2'h0);
      rdc("capture 0", TMR_OFS_CV0, 32'h100);
      rdc("capture 1", TMR_OFS_CV1, 32'h300);
      rdc("capture flags", TMR_OFS_FLAGS, 32'h10);
      wr(TMR_OFS_FLAGS, 32'h3F);
      // Counter mode on rising edges of capture input 1
      wr(TMR_OFS_CEDGE, 32'h0);
      wr(TMR_OFS_COUNT, 32'h0);
      wr(TMR_OFS_CSRC, 32'h5);
      wr(TMR_OFS_CTRL, 32'h1);
      for (int i = 0; i < 3; i++) begin
         pin(2'h2);
         pin(2'h0);
         pin(2'h1);
         pin(2'h0);
      end
      wr(TMR_OFS_CTRL, 32'h0);
      rdc("edge count", TMR_OFS_COUNT, 32'h3);
      // Both edges of input 0, then falling edges only
      wr(TMR_OFS_COUNT, 32'h0);
      wr(TMR_OFS_CSRC, 32'hB);
      wr(TMR_OFS_CTRL, 32'h1);
      pin(2'h1);
      pin(2'h0);
      wr(TMR_OFS_CSRC, 32'h2);
      pin(2'h1);
      pin(2'h0);
      wr(TMR_OFS_CTRL, 32'h0);
      rdc("both and fall count", TMR_OFS_COUNT, 32'h3);
      wr(TMR_OFS_CSRC, 32'h0);
      // Pins 100, then toggle, high and low on one match at 5
      wr(TMR_OFS_MOUT, 32'h1B4);
      repeat (2) @(posedge clk);
      chk("written pins", 32'h4, {29'h0, pins});
      wr(TMR_OFS_MV0, 32'h5);
      wr(TMR_OFS_MV1, 32'h5);
      wr(TMR_OFS_MV2, 32'h5);
      wr(TMR_OFS_COUNT, 32'h0);
      wr(TMR_OFS_CTRL, 32'h1);
      repeat (20) @(posedge clk);
      wr(TMR_OFS_CTRL, 32'h0);
      repeat (2) @(posedge clk);
      chk("match pins", 32'h3, {29'h0, pins});
      rdc("pin state", TMR_OFS_MOUT, 32'h1B3);
      // PWM on pin 0, period channel 3 alone resets
      wr(TMR_OFS_MACT, 32'h400);
      wr(TMR_OFS_PWM, 32'h1);
      wr(TMR_OFS_COUNT, 32'h3);
      repeat (2) @(posedge clk);
      chk("pwm low", 32'h0, {31'h0, pins[0]});
      wr(TMR_OFS_COUNT, 32'h7);
      repeat (2) @(posedge clk);
      chk("pwm high", 32'h1, {31'h0, pins[0]});
      end_of_test;
   end
endmodule

/* test/tmr_pins.sv */
// Purpose: Outside world of the timer, driving the capture pins
// Assumes: Pins are synchronous sources clocked by clk
// Notes: Levels change just after an edge, never mid-cycle

`timescale 1ns/1ps

module tmr_pins (
   // Clock
   input wire logic clk,
   // Levels asked for by the bench
   input wire logic [1:0] want,
   // Capture pins toward the timer
   output logic capture_input_0,
   output logic capture_input_1
);
   // Levels follow the bench one clock late; unknown only while reset holds the timer
   always @(posedge clk) begin
      capture_input_0 <= want[0];
      capture_input_1 <= want[1];
   end
endmodule
